// file: frb_pkg.sv
// ============================================================
// shared constants and types for the file-register/branch unit
package frb_pkg;

  // ============================================================
  // widths
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;
  localparam int IMM_W   = 11;
  localparam int PC_W    = 15;
  localparam int PAGE_W  = 7;
  localparam int RADDR_W = 4;

  // ============================================================
  // software register offsets (byte addresses)
  localparam logic [RADDR_W-1:0] REG_WORK   = 4'h0;
  localparam logic [RADDR_W-1:0] REG_PAGE   = 4'h4;
  localparam logic [RADDR_W-1:0] REG_STATUS = 4'h8;
  localparam logic [RADDR_W-1:0] REG_PC     = 4'hC;

  // ============================================================
  // field positions and reset values
  localparam int STATUS_Z_BIT   = 0;
  localparam int STATUS_BSY_BIT = 1;
  localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST  = 7'h00;
  localparam logic [PC_W-1:0]   PC_RST    = 15'h0000;
  localparam logic              Z_RST     = 1'b0;
  localparam logic [PC_W-1:0]   PC_STEP   = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // ============================================================
  // instruction group decoded by the core
  typedef enum logic [2:0] {
    OP_NOP                  = 3'b000,
    OP_CALL_VIA_WORKING_REG = 3'b001,
    OP_CLEAR_FILE_REG       = 3'b010,
    OP_COMPLEMENT_FILE_REG  = 3'b011,
    OP_DECREMENT_FILE_REG   = 3'b100,
    OP_DECREMENT_SKIP_ZERO  = 3'b101,
    OP_UNCONDITIONAL_BRANCH = 3'b110,
    OP_INCREMENT_FILE_REG   = 3'b111
  } frb_op_t;

  typedef struct packed {
    frb_op_t              op;
    logic [FADDR_W-1:0]   faddr;
    logic                 dest;   // 0: working reg, 1: file reg
    logic [IMM_W-1:0]     imm;
  } frb_instr_t;

  typedef struct packed {
    logic                 wr;
    logic [FADDR_W-1:0]   addr;
    logic [DATA_W-1:0]    data;
  } frb_fwrite_t;

  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_FLUSH = 1'b1
  } frb_state_t;

endpackage

// file: frb_exec.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module frb_exec
  import frb_pkg::*;
#(
  parameter int DW  = DATA_W,
  parameter int FAW = FADDR_W,
  parameter int IW  = IMM_W,
  parameter int PW  = PC_W
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // instruction issue
  input  wire frb_instr_t           instr,
  input  wire logic                 instr_valid,
  output logic                      instr_ready,
  output logic                      nop_slot,
  // file register bus
  output logic [FADDR_W-1:0]        file_raddr,
  input  wire logic [DATA_W-1:0]    file_rdata,
  output frb_fwrite_t               file_wr_ff,
  // return stack
  output logic                      push_ff,
  output logic [PC_W-1:0]           push_addr_ff,
  // core state
  output logic [PC_W-1:0]           pc_ff,
  output logic [DATA_W-1:0]         work_ff,
  output logic                      zero_ff,
  // software register port
  input  wire logic [RADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata_ff
);

  // ============================================================
  // elaboration checks: the datapath is fixed to the 8/7/11/15 layout
  if (DW != DATA_W || FAW != FADDR_W || IW != IMM_W || PW != PC_W) begin : g_chk
    $error("frb_exec: widths differ from the supported layout");
  end
  // a call target is the page latch beside the working reg, so the two must fill the pc
  if (PAGE_W + DATA_W != PC_W || PAGE_W < 4) begin : g_chk_page
    $error("frb_exec: page latch does not fit the program counter");
  end

  // ============================================================
  // helper functions
  // zero test shared by the skip decision and the flag update
  function automatic logic frb_is_zero(input logic [DATA_W-1:0] v);
    frb_is_zero = (v == DATA_ZERO);
  endfunction

  // true when the op writes its result somewhere through the dest bit
  function automatic logic frb_routes(input frb_op_t op);
    case (op)
      OP_COMPLEMENT_FILE_REG,
      OP_DECREMENT_FILE_REG,
      OP_DECREMENT_SKIP_ZERO,
      OP_INCREMENT_FILE_REG: frb_routes = 1'b1;
      default:               frb_routes = 1'b0;
    endcase
  endfunction

  // ============================================================
  // declarations
  frb_state_t           state_ff;
  frb_state_t           nxt_state;
  logic [PAGE_W-1:0]    page_latch_ff;
  logic [PC_W-1:0]      target_ff;
  logic [PC_W-1:0]      nxt_target;
  logic                 issue;
  logic [DATA_W-1:0]    f_val;
  logic [DATA_W-1:0]    result;
  logic                 wr_file;
  logic                 wr_work;
  logic                 upd_zero;
  logic                 two_cycle;
  logic                 is_call;
  logic                 is_branch;
  logic [PC_W-1:0]      pc_plus1;
  logic                 target_valid_ff;

  // ============================================================
  // issue handshake: one instruction per cycle except in a flush slot
  // instr_ready comes from the state register only, never from instr_valid
  assign instr_ready = (state_ff == ST_RUN);
  assign issue       = instr_valid && instr_ready;
  assign nop_slot    = (state_ff == ST_FLUSH);
  assign file_raddr  = instr.faddr;
  assign pc_plus1    = pc_ff + PC_STEP;
  assign is_call     = issue && (instr.op == OP_CALL_VIA_WORKING_REG);
  assign is_branch   = issue && (instr.op == OP_UNCONDITIONAL_BRANCH);

  // forward a pending file write so back-to-back ops see fresh data;
  // without it an op right after a write to the same address would use the old byte,
  // and one stage is enough because the write port holds a single pending write
  assign f_val = (file_wr_ff.wr && file_wr_ff.addr == instr.faddr) ?
                 file_wr_ff.data : file_rdata;

  // ============================================================
  // result datapath
  always_comb begin
    result    = DATA_ZERO;
    wr_file   = 1'b0;
    wr_work   = 1'b0;
    upd_zero  = 1'b0;
    two_cycle = 1'b0;
    if (issue) begin
      case (instr.op)
        OP_CLEAR_FILE_REG: begin
          result   = DATA_ZERO;
          wr_file  = 1'b1;
          upd_zero = 1'b1;
        end
        OP_COMPLEMENT_FILE_REG: begin
          result   = ~f_val;
          upd_zero = 1'b1;
        end
        OP_DECREMENT_FILE_REG: begin
          result   = f_val - DATA_ONE;
          upd_zero = 1'b1;
        end
        OP_DECREMENT_SKIP_ZERO: begin
          result    = f_val - DATA_ONE;
          upd_zero  = 1'b0;
          two_cycle = frb_is_zero(f_val - DATA_ONE);
        end
        OP_INCREMENT_FILE_REG: begin
          result   = f_val + DATA_ONE;
          upd_zero = 1'b1;
        end
        OP_CALL_VIA_WORKING_REG: begin
          two_cycle = 1'b1;
        end
        OP_UNCONDITIONAL_BRANCH: begin
          two_cycle = 1'b1;
        end
        default: begin
          // nop: no write, no flag, pc just steps
          result = DATA_ZERO;
        end
      endcase
      // dest 1 goes to file only
      if (frb_routes(instr.op)) begin
        wr_file = instr.dest;
        wr_work = !instr.dest;
      end
    end
  end

  // ============================================================
  // branch and call targets, computed at issue, applied in the flush slot
  // page and working reg are sampled at issue, so a software write in the flush
  // slot cannot bend a jump that is already under way
  always_comb begin
    nxt_target = target_ff;
    if (is_call) begin
      // working reg low, page latch high
      nxt_target = {page_latch_ff[6:0], work_ff};
    end else if (is_branch) begin
      nxt_target = {page_latch_ff[6:3], instr.imm};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_ff <= PC_RST;
    end else begin
      target_ff <= nxt_target;
    end
  end

  // ============================================================
  // sequencing: a two-cycle op spends its second cycle as a flush slot
  // no op here needs more than one extra cycle, so a single state bit suffices
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (two_cycle) begin
          nxt_state = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ============================================================
  // program counter; the jump lands only after the push was issued
  // a call or branch holds the pc in its issue cycle, so the pushed address is
  // taken from the caller's pc and not from the target
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= PC_RST;
    end else if (state_ff == ST_FLUSH && target_valid_ff) begin
      pc_ff <= target_ff;
    end else if (state_ff == ST_FLUSH) begin
      pc_ff <= pc_plus1;
    end else if (issue && !is_call && !is_branch) begin
      pc_ff <= pc_plus1;
    end
  end

  // ============================================================
  // remembers whether the pending flush slot is a jump or a skip
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_valid_ff <= 1'b0;
    end else if (issue) begin
      target_valid_ff <= is_call || is_branch;
    end
  end

  // ============================================================
  // return stack push, one cycle ahead of the PC change
  // push_ff is a one-cycle pulse; the stack must take it in that cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      push_ff      <= 1'b0;
      push_addr_ff <= PC_RST;
    end else begin
      push_ff <= is_call;
      if (is_call) begin
        push_addr_ff <= pc_plus1;
      end
    end
  end

  // ============================================================
  // file register write port, registered
  // only the strobe is cleared each cycle; address and data keep their last value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_wr_ff <= '0;
    end else begin
      file_wr_ff.wr <= wr_file;
      if (wr_file) begin
        file_wr_ff.addr <= instr.faddr;
        file_wr_ff.data <= result;
      end
    end
  end

  // ============================================================
  // working register: instruction result beats a software write
  // software should not write it while instructions issue, as such a write is lost whenever the issuing op writes the working reg
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_ff <= WORK_RST;
    end else if (wr_work) begin
      work_ff <= result;
    end else if (reg_wr && reg_addr == REG_WORK) begin
      work_ff <= reg_wdata[DATA_W-1:0];
    end
  end

  // ============================================================
  // zero flag: hardware update wins over a software write
  // a decrement-and-skip leaves upd_zero low, so a software write may land beside it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_ff <= Z_RST;
    end else if (upd_zero) begin
      zero_ff <= frb_is_zero(result);
    end else if (reg_wr && reg_addr == REG_STATUS) begin
      zero_ff <= reg_wdata[STATUS_Z_BIT];
    end
  end

  // ============================================================
  // page latch, software written; sampled when a jump issues
  // only bits 6:3 reach a branch target, all seven bits reach a call target
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_latch_ff <= PAGE_RST;
    end else if (reg_wr && reg_addr == REG_PAGE) begin
      page_latch_ff <= reg_wdata[PAGE_W-1:0];
    end
  end

  // ============================================================
  // register readback, data valid the cycle after the strobe only
  // reads have no side effects; pc and the nop-slot bit are read-only here
  // unmapped offsets read as zero so software can probe safely
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_WORK:   reg_rdata_ff <= {24'h00_0000, work_ff};
        REG_PAGE:   reg_rdata_ff <= {25'h000_0000, page_latch_ff};
        REG_STATUS: reg_rdata_ff <= {30'h0000_0000, nop_slot, zero_ff};
        REG_PC:     reg_rdata_ff <= {17'h0_0000, pc_ff};
        default:    reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

endmodule

// file: frb_exec_chk.sv
`timescale 1ns/100ps
// ============================================================
// port checker for the execution unit
module frb_exec_chk
  import frb_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire frb_instr_t        instr,
  input wire logic              instr_valid,
  input wire logic              instr_ready,
  input wire logic              nop_slot,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire frb_fwrite_t       file_wr_ff,
  input wire logic              push_ff,
  input wire logic [PC_W-1:0]   push_addr_ff,
  input wire logic [PC_W-1:0]   pc_ff,
  input wire logic [DATA_W-1:0] work_ff,
  input wire logic              zero_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic clean;
  // a forwarded write makes file_rdata stale, so operand checks skip that case
  assign take  = instr_valid && instr_ready;
  assign clean = take && !(file_wr_ff.wr && file_wr_ff.addr == instr.faddr);
  // the slot after a two-cycle op is refused once, then issue resumes
  sequence s_flush;
    nop_slot && !instr_ready ##1 instr_ready && !nop_slot;
  endsequence
  a_call_push_ret:
    assert property (take && instr.op == OP_CALL_VIA_WORKING_REG |=> push_ff
      && push_addr_ff == $past(pc_ff) + PC_STEP) else $error("call push wrong");
  a_call_pc_load:
    assert property (take && instr.op == OP_CALL_VIA_WORKING_REG |=> s_flush
      and (1'b1 ##1 pc_ff[7:0] == $past(work_ff, 2))) else $error("call target wrong");
  a_branch_pc_low:
    assert property (take && instr.op == OP_UNCONDITIONAL_BRANCH |=> s_flush
      and (1'b1 ##1 pc_ff[10:0] == $past(instr.imm, 2))) else $error("branch wrong");
  a_clear_file_zero:
    assert property (take && instr.op == OP_CLEAR_FILE_REG |=> file_wr_ff.wr && zero_ff
      && file_wr_ff.data == DATA_ZERO && file_wr_ff.addr == $past(instr.faddr))
      else $error("clear wrong");
  a_comp_work_dest:
    assert property (clean && instr.op == OP_COMPLEMENT_FILE_REG && !instr.dest |=>
      !file_wr_ff.wr && work_ff == ~$past(file_rdata)) else $error("complement wrong");
  a_dec_file_dest:
    assert property (clean && instr.op == OP_DECREMENT_FILE_REG && instr.dest |=>
      file_wr_ff.wr && file_wr_ff.data == $past(file_rdata) - DATA_ONE && $stable(work_ff))
      else $error("decrement wrong");
  a_skip_flags_kept:
    assert property (take && instr.op == OP_DECREMENT_SKIP_ZERO |=> $stable(zero_ff))
      else $error("skip touched flag");
  a_skip_zero_nop:
    assert property (clean && instr.op == OP_DECREMENT_SKIP_ZERO && file_rdata == DATA_ONE
      |=> s_flush) else $error("skip slot wrong");
  a_inc_zero_flag:
    assert property (clean && instr.op == OP_INCREMENT_FILE_REG |=>
      zero_ff == ($past(file_rdata) == 8'hFF)) else $error("increment flag wrong");
endmodule

bind frb_exec frb_exec_chk u_frb_exec_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .instr(instr), .instr_valid(instr_valid), .instr_ready(instr_ready),
  .nop_slot(nop_slot), .file_rdata(file_rdata), .file_wr_ff(file_wr_ff),
  .push_ff(push_ff), .push_addr_ff(push_addr_ff), .pc_ff(pc_ff),
  .work_ff(work_ff), .zero_ff(zero_ff));

// file: frb_exec_tb_top.sv
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the execution unit
module frb_exec_tb_top
  import frb_pkg::*;
;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            cpc;
    logic [7:0]      w;
    logic            z;
    frb_fwrite_t     fw;
    logic            push;
    logic [PC_W-1:0] pa;
  } frb_exp_t;
  logic              sys_clk     = 1'b0;
  logic              rst_n       = 1'b0;
  frb_instr_t        instr       = '0;
  logic              instr_valid = 1'b0;
  logic [3:0]        reg_addr    = 4'h0;
  logic [31:0]       reg_wdata   = 32'h0;
  logic              reg_wr      = 1'b0;
  logic              reg_rd      = 1'b0;
  logic              instr_ready, nop_slot, push_ff, zero_ff;
  logic [6:0]        file_raddr;
  logic [7:0]        file_rdata, work_ff, m_w;
  frb_fwrite_t       file_wr_ff;
  logic [PC_W-1:0]   push_addr_ff, pc_ff, m_pc;
  logic [31:0]       reg_rdata_ff;
  logic [6:0]        m_pg;
  logic              m_z;
  logic [7:0]        fmem [128];
  logic [7:0]        mmem [128];
  frb_exp_t          exp_q [$];
  logic [31:0]       rd_q [$];
  int                seed = 4827;
  int                num_errors = 0;
  int                total_checks = 0;

  always #5 sys_clk = ~sys_clk;

  frb_exec u_frb_exec (.sys_clk(sys_clk), .rst_n(rst_n), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .nop_slot(nop_slot),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr_ff(file_wr_ff),
    .push_ff(push_ff), .push_addr_ff(push_addr_ff), .pc_ff(pc_ff), .work_ff(work_ff),
    .zero_ff(zero_ff), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));

  // ============================================================
  // file register array answering the unit's read and write bus
  assign file_rdata = fmem[file_raddr];
  always @(posedge sys_clk) if (file_wr_ff.wr) fmem[file_wr_ff.addr] <= file_wr_ff.data;

  // ============================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // drivers: register port and instruction issue; reads and issues note their expectation, writes do not
  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] x);
    rd_q.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  // valid stays up between issues; a refused slot simply holds the next op
  task automatic issue(input frb_op_t op, input logic [6:0] fa, input logic d,
                       input logic [10:0] imm);
    frb_exp_t   e;
    logic [7:0] f;
    logic [7:0] r;
    int         n;
    instr <= {op, fa, d, imm};
    instr_valid <= 1'b1;
    n = 0;
    @(negedge sys_clk);
    while (instr_ready !== 1'b1) begin
      n++;
      if (n > 8) begin
        num_errors++;
        results();
      end
      @(negedge sys_clk);
    end
    f = mmem[fa];
    e = '0;
    e.pc = m_pc + PC_STEP;
    e.cpc = 1'b1;
    m_pc = e.pc;
    case (op)
      OP_CALL_VIA_WORKING_REG: r = f;
      OP_UNCONDITIONAL_BRANCH: r = f;
      OP_CLEAR_FILE_REG:       r = DATA_ZERO;
      OP_COMPLEMENT_FILE_REG:  r = ~f;
      OP_INCREMENT_FILE_REG:   r = f + DATA_ONE;
      default:                 r = f - DATA_ONE;
    endcase
    if (op == OP_CALL_VIA_WORKING_REG) begin
      e.push = 1'b1;
      e.pa = e.pc;
      m_pc = {m_pg, m_w};
      e.cpc = 1'b0;
    end else if (op == OP_UNCONDITIONAL_BRANCH) begin
      m_pc = {m_pg[6:3], imm};
      e.cpc = 1'b0;
    end else if (op != OP_NOP) begin
      if (op == OP_CLEAR_FILE_REG || d) begin
        e.fw = {1'b1, fa, r};
        mmem[fa] = r;
      end else m_w = r;
      if (op != OP_DECREMENT_SKIP_ZERO) m_z = (r == DATA_ZERO);
      else if (r == DATA_ZERO) m_pc = m_pc + PC_STEP;
    end
    e.w = m_w;
    e.z = m_z;
    exp_q.push_back(e);
    @(posedge sys_clk);
  endtask

  // ============================================================
  // monitor: samples takes at the falling edge, compares after the next rise
  initial begin : mon
    frb_exp_t e;
    logic     t;
    logic     r;
    forever begin
      @(negedge sys_clk);
      t = instr_valid && instr_ready;
      r = reg_rd;
      @(posedge sys_clk);
      #1;
      if (t === 1'b1) begin
        e = exp_q.pop_front();
        if (e.cpc) chk(pc_ff, e.pc);
        chk(work_ff, e.w);
        chk(zero_ff, e.z);
        chk(file_wr_ff.wr, e.fw.wr);
        if (e.fw.wr) chk(file_wr_ff, e.fw);
        chk(push_ff, e.push);
        if (e.push) chk(push_addr_ff, e.pa);
      end
      if (r === 1'b1) chk(reg_rdata_ff, rd_q.pop_front());
    end
  end

  // ============================================================
  // main sequence: directed corner ops, then seeded random traffic
  initial begin : main
    int i;
    for (i = 0; i < 128; i++) begin
      fmem[i] = 8'($random(seed));
      mmem[i] = fmem[i];
    end
    m_pc = 15'h0000;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rw(REG_PC, 32'h1234);
    rr(REG_PC, 32'h0);
    rr(REG_WORK, 32'h0);
    rr(4'h2, 32'h0);
    m_pg = 7'h5A;
    m_w = 8'hC3;
    m_z = 1'b1;
    rw(REG_PAGE, 32'h5A);
    rw(REG_WORK, 32'hC3);
    rw(REG_STATUS, 32'h3);
    rr(REG_STATUS, 32'h1);
    // page bits 6:3 and 3:0 differ here, so a wrong branch page shows
    issue(OP_CALL_VIA_WORKING_REG, 7'h00, 1'b0, 11'h000);
    issue(OP_UNCONDITIONAL_BRANCH, 7'h00, 1'b0, 11'h7FF);
    issue(OP_CLEAR_FILE_REG, 7'h7F, 1'b0, 11'h000);
    issue(OP_CLEAR_FILE_REG, 7'h05, 1'b0, 11'h000);
    issue(OP_INCREMENT_FILE_REG, 7'h05, 1'b1, 11'h000);
    // a nop lets the write land, so the skip below reads a clean 01 and is taken
    issue(OP_NOP, 7'h05, 1'b1, 11'h000);
    issue(OP_DECREMENT_SKIP_ZERO, 7'h05, 1'b1, 11'h000);
    issue(OP_DECREMENT_SKIP_ZERO, 7'h05, 1'b0, 11'h000);
    issue(OP_DECREMENT_FILE_REG, 7'h05, 1'b1, 11'h000);
    issue(OP_INCREMENT_FILE_REG, 7'h05, 1'b0, 11'h000);
    issue(OP_COMPLEMENT_FILE_REG, 7'h06, 1'b0, 11'h000);
    issue(OP_DECREMENT_FILE_REG, 7'h06, 1'b1, 11'h000);
    for (i = 0; i < 300; i++) begin
      issue(frb_op_t'(3'($random(seed))), 7'($random(seed)),
            1'($random(seed)), 11'($random(seed)));
    end
    instr_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rr(REG_PC, {17'h0, m_pc});
    rr(REG_WORK, {24'h0, m_w});
    rr(REG_STATUS, {31'h0, m_z});
    repeat (2) @(posedge sys_clk);
    results();
  end
endmodule
